// file: hdl/hjp_pkg.sv
// Shared constants for the host/test pin ends and the video status outputs
package hjp_pkg;
   // Serial host frame: command byte (read flag, address) then data byte
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 7;
   localparam int          FRAME_BITS   = 16;
   localparam int          CNT_W        = 5;
   localparam int          RW_POS       = FRAME_BITS - 1;
   localparam int          CMD_RW_POS   = DATA_W - 1;
   localparam logic [CNT_W-1:0] CNT_CMD_LAST = 5'h0007;
   localparam logic [CNT_W-1:0] CNT_FRM_LAST = 5'h000F;
   localparam logic [CNT_W-1:0] CNT_FULL     = 5'h0010;
   localparam logic [CNT_W-1:0] CNT_ONE      = 5'h0001;

   // Register addresses on the host serial port
   localparam logic [ADDR_W-1:0] ADDR_ERR_STATUS = 7'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ERR_MASK   = 7'h0001;

   // Error sources and their defaults
   localparam int               ERR_W        = 5;
   localparam logic [ERR_W-1:0] ERR_MASK_RST = 5'h001F;
   localparam logic [ERR_W-1:0] ERR_NONE     = 5'h0000;

   // Video word stream and timing reference words
   localparam int               WORD_W    = 10;
   localparam logic [WORD_W-1:0] TRS_ONES  = 10'h03FF;
   localparam logic [WORD_W-1:0] TRS_ZEROS = 10'h0000;
   localparam int               XYZ_F_BIT = 8;
   localparam int               XYZ_H_BIT = 6;

   // Crossing synchroniser width (cs active, read toggle, write toggle, test select)
   localparam int SYNC_W    = 4;
   localparam int SY_CS     = 0;
   localparam int SY_RD     = 1;
   localparam int SY_WR     = 2;
   localparam int SY_TEST   = 3;

   // Host serial clock made by division of the system clock
   localparam int MCLK_PERIOD_NS = 20;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int PH_W           = 3;
   localparam logic [PH_W-1:0] PH_LAST   = PH_W'(SCLK_PERIOD_NS / MCLK_PERIOD_NS - 1);
   localparam logic [PH_W-1:0] PH_RISE   = PH_W'(SCLK_PERIOD_NS / MCLK_PERIOD_NS / 2);
   localparam logic [PH_W-1:0] PH_SAMPLE = PH_W'(SCLK_PERIOD_NS / MCLK_PERIOD_NS / 2 - 1);
   localparam logic [PH_W-1:0] PH_ZERO   = 3'h0000;
   localparam logic [PH_W-1:0] PH_ONE    = 3'h0001;
   localparam int IN_SYNC_W = 2;
   localparam int IS_DOUT   = 0;
   localparam int IS_ERR    = 1;

   typedef enum logic [1:0] {HJP_IDLE, HJP_LEAD, HJP_SHIFT, HJP_TRAIL} hjp_state_t;
endpackage : hjp_pkg

// file: hdl/hjp_link_if.sv
// Pins between the host controller or tester and the deserializer status block
`timescale 1ns/1ns
interface hjp_link_if;
   logic test_sel;
   logic cs_tms;
   logic sclk_tck;
   logic serial_in;
   logic shared_serial_out_pin;
   logic fifo_load_strobe_n;
   logic data_error_n;

   modport dev (
      input  test_sel,
      input  cs_tms,
      input  sclk_tck,
      input  serial_in,
      output shared_serial_out_pin,
      output fifo_load_strobe_n,
      output data_error_n
   );

   modport host (
      output test_sel,
      output cs_tms,
      output sclk_tck,
      output serial_in,
      input  shared_serial_out_pin,
      input  fifo_load_strobe_n,
      input  data_error_n
   );
endinterface : hjp_link_if

// file: hdl/hjp_dev_end.sv
// Device end: shared host/test pins, FIFO load strobe and latched error flag
`timescale 1ns/1ns
// Behaviour
// - FIFO strobe low one word clock at SAV
// - Select low: shared pin is chip select
// - Select high: shared pin is TMS
// - Host mode: shared clock is burst clock
// - Test mode: shared clock is TCK
// - Host mode: serial out shifts register contents
// - Test mode: serial out is TDO
// - Error flag low on any listed error whose mask bit is high
// - Flag stays low until next frame
// - Status read releases latched flag
// - Flag high while stream error free
// - Mask bits high select contributing errors
// - All errors monitored after reset
// - Unused host port pins tied high
// - Reset restores error and mask registers
module hjp_dev_end (
   // Parallel word clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_resetn,
   // Link pins
   hjp_link_if.dev                          link,
   // Aligned video word stream and error detectors
   input  wire logic [hjp_pkg::WORD_W-1:0]  i_word,
   input  wire logic [hjp_pkg::ERR_W-1:0]   i_err,
   // Boundary-scan logic
   input  wire logic                        i_jtag_tdo,
   output logic                             o_jtag_tms,
   output logic                             o_jtag_tck,
   // Status view
   output logic [hjp_pkg::ERR_W-1:0]        o_err_status,
   output logic [hjp_pkg::ERR_W-1:0]        o_err_mask,
   output logic                             o_test_mode
);
   import hjp_pkg::*;

   // Link clock side
   logic                  frame_idle;
   logic [CNT_W-1:0]      bit_cnt_q;
   logic [FRAME_BITS-1:0] in_sh_q;
   logic [FRAME_BITS-1:0] shift_next;
   logic [DATA_W-1:0]     out_sh_q;
   logic [DATA_W-1:0]     read_word;
   logic                  rd_tog_q;
   logic                  wr_tog_q;
   logic [ADDR_W-1:0]     waddr_q;
   logic [DATA_W-1:0]     wdata_q;
   logic                  host_serial_out;
   logic                  cmd_is_read;
   logic [ADDR_W-1:0]     cmd_addr;

   // Word clock side
   logic [SYNC_W-1:0]     sy1_q;
   logic [SYNC_W-1:0]     sy2_q;
   logic [SYNC_W-1:0]     sy3_q;
   logic [SYNC_W-1:0]     acc_q;
   logic [SYNC_W-1:0]     prev_q;
   logic                  rd_ev;
   logic                  wr_ev;
   logic [ERR_W-1:0]      status_q;
   logic [ERR_W-1:0]      status_d;
   logic [ERR_W-1:0]      mask_q;
   logic [ERR_W-1:0]      status_snap_q;
   logic [ERR_W-1:0]      mask_snap_q;
   logic [WORD_W-1:0]     w1_q;
   logic [WORD_W-1:0]     w2_q;
   logic [WORD_W-1:0]     w3_q;
   logic                  trs_hit;
   logic                  field_q;
   logic                  frame_ev;
   logic                  err_clr;
   logic                  fifo_q;
   logic                  err_n_q;

   // Host port idles while chip select is high or the test port owns the pins
   assign frame_idle  = link.cs_tms | link.test_sel;
   assign shift_next  = {in_sh_q[FRAME_BITS-2:0], link.serial_in};
   assign cmd_is_read = shift_next[CMD_RW_POS];
   assign cmd_addr    = shift_next[CMD_RW_POS-1:0];
   assign read_word   = (cmd_addr == ADDR_ERR_STATUS) ? DATA_W'(status_snap_q)
                      : (cmd_addr == ADDR_ERR_MASK)   ? DATA_W'(mask_snap_q)
                      : '0;

   // Frame state ends with chip select, so a stopped burst clock cannot strand it
   always_ff @(posedge link.sclk_tck or posedge frame_idle) begin
      if (frame_idle) begin
         bit_cnt_q <= '0;
         in_sh_q   <= '0;
      end else if (bit_cnt_q != CNT_FULL) begin
         bit_cnt_q <= bit_cnt_q + CNT_ONE;
         in_sh_q   <= shift_next;
      end
   end

   always_ff @(posedge link.sclk_tck or posedge frame_idle) begin
      if (frame_idle) begin
         out_sh_q <= '0;
      end else if (bit_cnt_q == CNT_CMD_LAST && cmd_is_read) begin
         out_sh_q <= read_word;
      end else begin
         out_sh_q <= {out_sh_q[DATA_W-2:0], 1'b0};
      end
   end

   assign host_serial_out            = out_sh_q[DATA_W-1];
   assign link.shared_serial_out_pin = link.test_sel ? i_jtag_tdo : host_serial_out;

   // Toggles survive between frames; only the system reset clears them
   always_ff @(posedge link.sclk_tck or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_tog_q <= 1'b0;
      end else if (!frame_idle && bit_cnt_q == CNT_CMD_LAST && cmd_is_read
                   && cmd_addr == ADDR_ERR_STATUS) begin
         rd_tog_q <= ~rd_tog_q;
      end
   end

   always_ff @(posedge link.sclk_tck or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_tog_q <= 1'b0;
         waddr_q  <= '0;
         wdata_q  <= '0;
      end else if (!frame_idle && bit_cnt_q == CNT_FRM_LAST && !shift_next[RW_POS]) begin
         waddr_q  <= shift_next[RW_POS-1:DATA_W];
         wdata_q  <= shift_next[DATA_W-1:0];
         wr_tog_q <= ~wr_tog_q;
      end
   end

   // JTAG pins; TMS parks high in host mode to hold the TAP in reset
   assign o_jtag_tms = link.test_sel ? link.cs_tms : 1'b1;
   assign o_jtag_tck = link.test_sel & link.sclk_tck;

   // Crossing into the word clock: a change counts when stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         sy1_q  <= '0;
         sy2_q  <= '0;
         sy3_q  <= '0;
         acc_q  <= '0;
         prev_q <= '0;
      end else begin
         sy1_q  <= {link.test_sel, wr_tog_q, rd_tog_q, ~frame_idle};
         sy2_q  <= sy1_q;
         sy3_q  <= sy2_q;
         acc_q  <= (sy3_q & ~(sy2_q ^ sy3_q)) | (acc_q & (sy2_q ^ sy3_q));
         prev_q <= acc_q;
      end
   end

   assign rd_ev = acc_q[SY_RD] ^ prev_q[SY_RD];
   assign wr_ev = acc_q[SY_WR] ^ prev_q[SY_WR];

   // Snapshot frozen during a frame so the link side reads a stable word
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         status_snap_q <= ERR_NONE;
         mask_snap_q   <= ERR_MASK_RST;
      end else if (!acc_q[SY_CS]) begin
         status_snap_q <= status_q;
         mask_snap_q   <= mask_q;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         mask_q <= ERR_MASK_RST;
      end else if (wr_ev && waddr_q == ADDR_ERR_MASK) begin
         mask_q <= wdata_q[ERR_W-1:0];
      end
   end

   // Timing reference detection on the aligned stream
   assign trs_hit  = (w3_q == TRS_ONES) && (w2_q == TRS_ZEROS) && (w1_q == TRS_ZEROS);
   assign frame_ev = trs_hit && (i_word[XYZ_F_BIT] != field_q);

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         w1_q    <= '0;
         w2_q    <= '0;
         w3_q    <= '0;
         field_q <= 1'b0;
      end else begin
         w1_q <= i_word;
         w2_q <= w1_q;
         w3_q <= w2_q;
         if (trs_hit) begin
            field_q <= i_word[XYZ_F_BIT];
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         fifo_q <= 1'b1;
      end else begin
         fifo_q <= ~(trs_hit & ~i_word[XYZ_H_BIT]);
      end
   end

   // New errors win over a clear in the same cycle
   assign err_clr  = rd_ev | frame_ev;
   assign status_d = i_err | (status_q & ~{ERR_W{err_clr}});

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         status_q <= ERR_NONE;
         err_n_q  <= 1'b1;
      end else begin
         status_q <= status_d;
         err_n_q  <= ~|(status_d & mask_q);
      end
   end

   assign link.fifo_load_strobe_n = fifo_q;
   assign link.data_error_n       = err_n_q;
   assign o_err_status            = status_q;
   assign o_err_mask              = mask_q;
   assign o_test_mode             = acc_q[SY_TEST];
endmodule : hjp_dev_end

// file: hdl/hjp_host_end.sv
// Host end: drives the shared pins, runs serial register frames, watches the flag
`timescale 1ns/1ns
module hjp_host_end (
   // System clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_resetn,
   // Link pins
   hjp_link_if.host                         link,
   // Mode and direct test pins
   input  wire logic                        i_test_mode,
   input  wire logic                        i_tms,
   input  wire logic                        i_tck,
   input  wire logic                        i_tdi,
   // Register access requests
   input  wire logic                        i_req,
   input  wire logic                        i_rd,
   input  wire logic [hjp_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [hjp_pkg::DATA_W-1:0]  i_wdata,
   output logic                             o_busy,
   output logic                             o_done,
   output logic [hjp_pkg::DATA_W-1:0]       o_rdata,
   // Observed device outputs
   output logic                             o_tdo,
   output logic                             o_data_error_n
);
   import hjp_pkg::*;

   hjp_state_t            state_q;
   logic [PH_W-1:0]       phase_q;
   logic [CNT_W-1:0]      bit_q;
   logic [FRAME_BITS-1:0] tx_q;
   logic [DATA_W-1:0]     rx_q;
   logic                  cs_q;
   logic                  sclk_q;
   logic                  out_q;
   logic                  test_q;
   logic                  done_q;
   logic [DATA_W-1:0]     rdata_q;
   logic [IN_SYNC_W-1:0]  is1_q;
   logic [IN_SYNC_W-1:0]  is2_q;
   logic [IN_SYNC_W-1:0]  is3_q;
   logic [IN_SYNC_W-1:0]  iacc_q;

   // Idle host pins rest high, as an unused port would be tied
   assign link.test_sel  = test_q;
   assign link.cs_tms    = test_q ? i_tms : cs_q;
   assign link.sclk_tck  = test_q ? i_tck : sclk_q;
   assign link.serial_in = test_q ? i_tdi : out_q;

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         test_q <= 1'b0;
      end else if (state_q == HJP_IDLE) begin
         test_q <= i_test_mode;
      end
   end

   // Device outputs cross in: a change counts when stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         is1_q  <= '1;
         is2_q  <= '1;
         is3_q  <= '1;
         iacc_q <= '1;
      end else begin
         is1_q  <= {link.data_error_n, link.shared_serial_out_pin};
         is2_q  <= is1_q;
         is3_q  <= is2_q;
         iacc_q <= (is3_q & ~(is2_q ^ is3_q)) | (iacc_q & (is2_q ^ is3_q));
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state_q <= HJP_IDLE;
         phase_q <= PH_ZERO;
         bit_q   <= '0;
         tx_q    <= '0;
         rx_q    <= '0;
         cs_q    <= 1'b1;
         sclk_q  <= 1'b1;
         out_q   <= 1'b1;
         done_q  <= 1'b0;
         rdata_q <= '0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            HJP_IDLE: begin
               phase_q <= PH_ZERO;
               if (i_req && !i_test_mode && !test_q) begin
                  tx_q    <= {i_rd, i_addr, i_rd ? {DATA_W{1'b0}} : i_wdata};
                  cs_q    <= 1'b0;
                  state_q <= HJP_LEAD;
               end
            end
            HJP_LEAD: begin
               phase_q <= phase_q + PH_ONE;
               if (phase_q == PH_LAST) begin
                  bit_q   <= '0;
                  state_q <= HJP_SHIFT;
               end
            end
            HJP_SHIFT: begin
               phase_q <= phase_q + PH_ONE;
               if (phase_q == PH_ZERO) begin
                  sclk_q <= 1'b0;
                  out_q  <= tx_q[FRAME_BITS-1];
               end else if (phase_q == PH_RISE) begin
                  sclk_q <= 1'b1;
                  tx_q   <= {tx_q[FRAME_BITS-2:0], 1'b0};
               end
               if (phase_q == PH_SAMPLE && bit_q > CNT_CMD_LAST) begin
                  rx_q <= {rx_q[DATA_W-2:0], iacc_q[IS_DOUT]};
               end
               if (phase_q == PH_LAST) begin
                  bit_q <= bit_q + CNT_ONE;
                  if (bit_q == CNT_FRM_LAST) begin
                     cs_q    <= 1'b1;
                     out_q   <= 1'b1;
                     state_q <= HJP_TRAIL;
                  end
               end
            end
            HJP_TRAIL: begin
               // Gap lets the device refresh its snapshot before the next frame
               phase_q <= phase_q + PH_ONE;
               if (phase_q == PH_LAST) begin
                  rdata_q <= rx_q;
                  done_q  <= 1'b1;
                  state_q <= HJP_IDLE;
               end
            end
            default: begin
               state_q <= HJP_IDLE;
            end
         endcase
      end
   end

   assign o_busy         = (state_q != HJP_IDLE);
   assign o_done         = done_q;
   assign o_rdata        = rdata_q;
   assign o_tdo          = iacc_q[IS_DOUT];
   assign o_data_error_n = iacc_q[IS_ERR];
endmodule : hjp_host_end

// file: testbench/hjp_link_chk.sv
// Checker for the link pins, the load strobe and the error flag
`timescale 1ns/1ns
module hjp_link_chk (
   // Clocks and reset
   input  wire logic i_mclk,
   input  wire logic i_pclk,
   input  wire logic i_resetn,
   // Link pins
   input  wire logic test_sel,
   input  wire logic cs_tms,
   input  wire logic sclk_tck,
   input  wire logic serial_in,
   input  wire logic shared_serial_out_pin,
   input  wire logic fifo_load_strobe_n,
   input  wire logic data_error_n
);
   // SAV needs four words, so two strobes are at least four words apart
   a_strobe_one_word: assert property (
      @(posedge i_pclk) disable iff (!i_resetn)
      $fell(fifo_load_strobe_n) |=> fifo_load_strobe_n[*3])
      else $error("load strobe low for more than one word");
   a_reset_outputs_high: assert property (
      @(posedge i_pclk) disable iff (!i_resetn)
      $rose(i_resetn) |-> fifo_load_strobe_n && data_error_n)
      else $error("strobe or flag not high after reset");
   a_idle_sclk_high: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      cs_tms && !test_sel && !$past(test_sel) |-> sclk_tck)
      else $error("burst clock not high while deselected");
   a_cs_lead_time: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      $fell(cs_tms) && !test_sel |-> sclk_tck[*8])
      else $error("burst clock moved during select lead");
   a_sclk_low_half: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      $fell(sclk_tck) && !test_sel |-> !sclk_tck[*4] ##1 sclk_tck)
      else $error("burst clock low phase not four cycles");
   a_sclk_high_half: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      $rose(sclk_tck) && !test_sel && !cs_tms |-> sclk_tck[*4])
      else $error("burst clock high phase too short");
   a_data_on_fall: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      !test_sel && !cs_tms && $changed(serial_in) |-> $fell(sclk_tck))
      else $error("serial data moved away from clock fall");
   // Test mode exit leaves the device's synced mode behind for a few cycles
   a_host_serial_out_idle_low: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      cs_tms && $past(cs_tms) && !test_sel && !$past(test_sel, 8)
      |-> !shared_serial_out_pin)
      else $error("serial out not low while deselected");
   c_strobe: cover property (@(posedge i_pclk) disable iff (!i_resetn)
      $fell(fifo_load_strobe_n));
   c_flag: cover property (@(posedge i_pclk) disable iff (!i_resetn)
      $fell(data_error_n));
   c_frame: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      $fell(cs_tms) && !test_sel);
   c_test: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      $rose(test_sel));
endmodule : hjp_link_chk

// file: testbench/tb_top.sv
// Bench joining host end and device end over the link
`timescale 1ns/1ns
module tb_top;
   import hjp_pkg::*;
   typedef struct {logic [ERR_W-1:0] err; logic [ERR_W-1:0] mask; logic flag;} hjp_row_t;
   logic              mclk, pclk, resetn, test_mode, tms, tck, tdi, req, rd, jtag_tdo;
   logic              busy, done, tdo, host_flag_n, jtag_tms, jtag_tck, dev_test;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [WORD_W-1:0] word;
   logic [ERR_W-1:0]  err, err_status, err_mask;
   int                mismatches, n_tests, cycles;
   hjp_row_t          rows [8];
   hjp_link_if hjp_link_if_inst ();
   wire flag_n = hjp_link_if_inst.data_error_n;
   wire fifo_n = hjp_link_if_inst.fifo_load_strobe_n;

   hjp_dev_end hjp_dev_end_inst (.i_mclk(pclk), .i_resetn(resetn), .link(hjp_link_if_inst),
      .i_word(word), .i_err(err), .i_jtag_tdo(jtag_tdo), .o_jtag_tms(jtag_tms),
      .o_jtag_tck(jtag_tck), .o_err_status(err_status), .o_err_mask(err_mask),
      .o_test_mode(dev_test));
   hjp_host_end hjp_host_end_inst (.i_mclk(mclk), .i_resetn(resetn),
      .link(hjp_link_if_inst), .i_test_mode(test_mode), .i_tms(tms), .i_tck(tck),
      .i_tdi(tdi), .i_req(req), .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_busy(busy),
      .o_done(done), .o_rdata(rdata), .o_tdo(tdo), .o_data_error_n(host_flag_n));
   hjp_link_chk hjp_link_chk_inst (.i_mclk(mclk), .i_pclk(pclk), .i_resetn(resetn),
      .test_sel(hjp_link_if_inst.test_sel), .cs_tms(hjp_link_if_inst.cs_tms),
      .sclk_tck(hjp_link_if_inst.sclk_tck), .serial_in(hjp_link_if_inst.serial_in),
      .shared_serial_out_pin(hjp_link_if_inst.shared_serial_out_pin),
      .fifo_load_strobe_n(fifo_n), .data_error_n(flag_n));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Word clock unrelated in phase to the host clock
   initial begin
      pclk = 1'b0;
      #7;
      forever #15 pclk = ~pclk;
   end

   task automatic final_report;
      $display("counts: %0d compared, %0d mismatched", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic host_xfer(input logic r, input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d);
      @(posedge mclk);
      req   <= 1'b1;
      rd    <= r;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      req <= 1'b0;
      for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge mclk);
      chk(8'(done), 8'h01);
   endtask : host_xfer

   // Timing reference then idle words, counting strobe lows
   task automatic send_trs(input logic [WORD_W-1:0] xyz, input int exp_lows);
      logic [WORD_W-1:0] seq [4];
      int                lows;
      seq  = '{TRS_ONES, TRS_ZEROS, TRS_ZEROS, xyz};
      lows = 0;
      for (int k = 0; k < 8; k++) begin
         @(posedge pclk);
         word <= (k < 4) ? seq[k] : 10'h0155;
         @(negedge pclk);
         if (fifo_n === 1'b0) lows++;
      end
      chk(8'(lows), 8'(exp_lows));
   endtask : send_trs

   task automatic pulse_err(input logic [ERR_W-1:0] e);
      @(posedge pclk);
      err <= e;
      @(posedge pclk);
      err <= '0;
      repeat (3) @(negedge pclk);
   endtask : pulse_err

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         mismatches++;
         final_report();
      end
   end

   initial begin
      resetn = 1'b0;
      test_mode = 1'b0;
      tms = 1'b0;
      tck = 1'b0;
      tdi = 1'b0;
      req = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      word = 10'h0155;
      err = '0;
      jtag_tdo = 1'b0;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      // Masked rows first so the run ends with every source monitored
      rows = '{'{5'h01, 5'h1E, 1'b1}, '{5'h10, 5'h0F, 1'b1}, '{5'h06, 5'h04, 1'b0},
               '{5'h01, 5'h1F, 1'b0}, '{5'h02, 5'h1F, 1'b0}, '{5'h04, 5'h1F, 1'b0},
               '{5'h08, 5'h1F, 1'b0}, '{5'h10, 5'h1F, 1'b0}};
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      chk(8'(err_mask), 8'(ERR_MASK_RST));
      chk(8'(err_status), 8'h00);
      chk(8'(flag_n), 8'h01);
      chk(8'(hjp_link_if_inst.cs_tms), 8'h01);
      chk(8'(hjp_link_if_inst.sclk_tck), 8'h01);
      chk(8'(jtag_tms), 8'h01);
      chk(8'(jtag_tck), 8'h00);
      $display("test reset done");
      send_trs(10'h0200, 1);
      send_trs(10'h0240, 0);
      $display("test strobe done");
      foreach (rows[n]) begin
         host_xfer(1'b0, ADDR_ERR_MASK, 8'(rows[n].mask));
         host_xfer(1'b1, ADDR_ERR_MASK, 8'h00);
         chk(rdata, 8'(rows[n].mask));
         pulse_err(rows[n].err);
         chk(8'(err_status), 8'(rows[n].err));
         chk(8'(flag_n), 8'(rows[n].flag));
         host_xfer(1'b1, ADDR_ERR_STATUS, 8'h00);
         chk(rdata, 8'(rows[n].err));
         repeat (10) @(negedge pclk);
         chk(8'(flag_n), 8'h01);
         chk(8'(err_status), 8'h00);
         $display("test row %0d done", n);
      end
      pulse_err(5'h08);
      repeat (20) @(negedge pclk);
      chk(8'(flag_n), 8'h00);
      chk(8'(host_flag_n), 8'h00);
      send_trs(10'h0300, 1);
      chk(8'(flag_n), 8'h01);
      $display("test frame done");
      @(posedge mclk);
      test_mode <= 1'b1;
      repeat (12) @(negedge mclk);
      chk(8'(hjp_link_if_inst.test_sel), 8'h01);
      chk(8'(dev_test), 8'h01);
      @(posedge mclk);
      req <= 1'b1;
      @(posedge mclk);
      req <= 1'b0;
      @(negedge mclk);
      chk(8'(busy), 8'h00);
      for (int v = 0; v < 8; v++) begin
         @(posedge mclk);
         tms <= v[0];
         tck <= v[1];
         tdi <= v[2];
         @(posedge pclk);
         jtag_tdo <= v[0] ^ v[2];
         repeat (6) @(negedge mclk);
         chk(8'(jtag_tms), 8'(v[0]));
         chk(8'(jtag_tck), 8'(v[1]));
         chk(8'(hjp_link_if_inst.shared_serial_out_pin), 8'(v[0] ^ v[2]));
         chk(8'(tdo), 8'(v[0] ^ v[2]));
      end
      @(posedge mclk);
      test_mode <= 1'b0;
      repeat (12) @(negedge mclk);
      chk(8'(dev_test), 8'h00);
      chk(8'(jtag_tms), 8'h01);
      host_xfer(1'b1, ADDR_ERR_MASK, 8'h00);
      chk(rdata, 8'h1F);
      $display("test jtag done");
      // Unmapped address: write lands nowhere, read returns zero
      host_xfer(1'b0, 7'h02, 8'h00);
      chk(8'(err_mask), 8'(ERR_MASK_RST));
      host_xfer(1'b1, 7'h02, 8'h00);
      chk(rdata, 8'h00);
      $display("test unmapped done");
      host_xfer(1'b0, ADDR_ERR_MASK, 8'h03);
      pulse_err(5'h01);
      chk(8'(flag_n), 8'h00);
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(negedge pclk);
      chk(8'(err_mask), 8'(ERR_MASK_RST));
      chk(8'(err_status), 8'h00);
      chk(8'(flag_n), 8'h01);
      $display("test rereset done");
      final_report();
   end
endmodule : tb_top
